// [core/bvs_regs.vh]
// register offsets, field positions, reset codes and voltage table constants
`ifndef BVS_REGS_VH
`define BVS_REGS_VH
`define BVS_ADDR_W 8
`define BVS_DATA_W 8
`define BVS_CTRL_ADDR 8'h0e
`define BVS_XSEL_BIT 7
`define BVS_CODE_HI 5
`define BVS_CODE_LO 0
`define BVS_CODE_W 6
`define BVS_UNLOCK_KEY 8'h7d
`define BVS_KEY_CLEAR 8'h00
`define BVS_RST_CODE_V0 6'h1e
`define BVS_RST_CODE_V1 6'h18
`define BVS_RST_CODE_V2 6'h12
`define BVS_MV_W 12
`define BVS_MV_BASE 12'h384
`define BVS_MV_FINE 12'h019
`define BVS_MV_COARSE 12'h032
`define BVS_FINE_END 6'h18
`define BVS_COARSE_END 6'h34
`define BVS_TOP_START 6'h38
`define BVS_MV_2900 12'hb54
`define BVS_MV_3000 12'hbb8
`define BVS_MV_3100 12'hc1c
`define BVS_MV_3200 12'hc80
`define BVS_MV_3300 12'hce4
`endif

// [core/bvs_buck_voltage_select.v]
// voltage-select control register for the first step-down converter
// the block holds one 8-bit control register of the first step-down
// converter: a source-select bit, a spare bit and a 6-bit voltage code.
// writes arrive as a one-cycle strobe with address and data; reads use a
// separate address and return data one cycle later.
// writes are honoured only while the password register, kept outside
// this block, holds the unlock key. the block asks for that key to be
// wiped after every finished bus transaction, so one unlock covers one
// transaction at most, however many writes it carries.
// the millivolt output is a convenience for the analog side and for
// checking; the converter itself only needs the code and the select bit.
// limitation: the key is sampled in the cycle of the write strobe, not at
// the start of the transaction.
`timescale 1ns/100ps
`include "bvs_regs.vh"
module bvs_buck_voltage_select #(
    parameter [1:0] VARIANT = 2'h0 // 0: code 0x1e, 1: 0x18, 2: 0x12
) (
    input wire clk_i,
    input wire reset_n_i,
    input wire txn_end_i, // one-cycle pulse: a bus transaction finished
    input wire wr_en_i, // one-cycle write strobe
    input wire [`BVS_ADDR_W-1:0] wr_addr_i,
    input wire [`BVS_DATA_W-1:0] wr_data_i,
    input wire [`BVS_ADDR_W-1:0] rd_addr_i,
    input wire [`BVS_DATA_W-1:0] unlock_key_i, // password register content
    output reg [`BVS_DATA_W-1:0] rd_data_o,
    output reg external_voltage_select_o,
    output reg [`BVS_CODE_W-1:0] buck_one_voltage_code_o,
    output reg reg_mode_o, // high while voltage follows the code
    output reg [`BVS_MV_W-1:0] target_mv_o, // requested output in millivolts
    output reg key_clear_o, // pulse: password register must return to zero
    output reg write_refused_o // pulse: locked write to this register dropped
);

    // reset code for the chosen variant; selection bit always cleared
    function [`BVS_CODE_W-1:0] rst_code;
        input [1:0] v;
        begin
            case (v)
                2'h1: rst_code = `BVS_RST_CODE_V1;
                2'h2: rst_code = `BVS_RST_CODE_V2;
                default: rst_code = `BVS_RST_CODE_V0;
            endcase
        end
    endfunction

    // code to millivolts, piecewise table
    function [`BVS_MV_W-1:0] code_to_mv;
        input [`BVS_CODE_W-1:0] c;
        reg [`BVS_MV_W-1:0] cw;
        begin
            cw = {{(`BVS_MV_W-`BVS_CODE_W){1'b0}}, c};
            if (c <= `BVS_FINE_END) begin
                code_to_mv = `BVS_MV_BASE + cw * `BVS_MV_FINE;
            end else if (c <= `BVS_COARSE_END) begin
                code_to_mv = `BVS_MV_2900
                    - ({{(`BVS_MV_W-`BVS_CODE_W){1'b0}}, `BVS_COARSE_END} - cw)
                    * `BVS_MV_COARSE;
            end else if (c >= `BVS_TOP_START) begin
                code_to_mv = `BVS_MV_3300;
            end else begin
                case (c[1:0])
                    2'h1: code_to_mv = `BVS_MV_3000;
                    2'h2: code_to_mv = `BVS_MV_3100;
                    default: code_to_mv = `BVS_MV_3200;
                endcase
            end
        end
    endfunction

    // true when an address selects this register; both bus sides decode it
    // kept as a function so the two decodes cannot drift apart
    function is_ctrl;
        input [`BVS_ADDR_W-1:0] a;
        begin
            is_ctrl = (a == `BVS_CTRL_ADDR);
        end
    endfunction

    // reset code of the chosen variant, fixed at elaboration
    localparam [`BVS_CODE_W-1:0] RST_CODE = rst_code(VARIANT);
    // millivolt figure that belongs to the reset code, so the target output
    // is already right in the first cycle after reset
    localparam [`BVS_MV_W-1:0] RST_MV = code_to_mv(RST_CODE);
    // register word as read straight after reset: both upper bits clear
    localparam [`BVS_DATA_W-1:0] RST_WORD = {1'b0, 1'b0, RST_CODE};

    // register fields and decode nets
    reg xsel_r; // external source select, bit 7
    reg unused_r; // bit 6 storage; read back, drives nothing
    reg [`BVS_CODE_W-1:0] code_r; // output-voltage code, bits 5 down to 0
    wire hit_w; // write strobe aimed at this register
    wire unlocked_w; // password register holds the unlock value
    wire take_w; // write accepted this cycle
    wire refuse_w; // write aimed here but dropped by the lock
    wire rd_hit_w; // read address selects this register
    wire [`BVS_DATA_W-1:0] word_w; // register contents in read order
    wire [`BVS_MV_W-1:0] mv_w; // millivolt figure of the held code

    // write-side address decode
    assign hit_w = wr_en_i && is_ctrl(wr_addr_i);
    // key must match exactly; any other value keeps the lock
    assign unlocked_w = (unlock_key_i == `BVS_UNLOCK_KEY);
    // the lock is judged in the same cycle as the strobe; the host has to
    // load the key before it starts the protected write
    assign take_w = hit_w && unlocked_w;
    assign refuse_w = hit_w && !unlocked_w;
    // read-side address decode; the read port has no strobe of its own
    assign rd_hit_w = is_ctrl(rd_addr_i);
    // field packing: select on top, spare bit, then the code
    assign word_w = {xsel_r, unused_r, code_r};
    // table lookup kept combinational; the output flop hides its depth
    assign mv_w = code_to_mv(code_r);

    // source select bit; a locked write leaves it alone
    // the write lands at the strobe edge and reaches the pins one cycle later
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            xsel_r <= 1'b0;
        end else if (take_w) begin
            xsel_r <= wr_data_i[`BVS_XSEL_BIT];
        end
    end

    // spare bit 6: stored so that it reads back as written, no other effect
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            unused_r <= 1'b0;
        end else if (take_w) begin
            unused_r <= wr_data_i[`BVS_XSEL_BIT-1];
        end
    end

    // voltage code; external mode leaves it as it is, but every accepted write
    // loads it, so the write that switches back to register mode also sets the code
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            code_r <= RST_CODE;
        end else if (take_w) begin
            code_r <= wr_data_i[`BVS_CODE_HI:`BVS_CODE_LO];
        end
    end

    // read data, registered: it shows the register one cycle after the
    // address; other addresses read as zero
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rd_data_o <= RST_WORD;
        end else if (rd_hit_w) begin
            rd_data_o <= word_w;
        end else begin
            rd_data_o <= {`BVS_DATA_W{1'b0}};
        end
    end

    // select bit as seen by the converter
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            external_voltage_select_o <= 1'b0;
        end else begin
            external_voltage_select_o <= xsel_r;
        end
    end

    // code as seen by the converter; only meaningful in register mode
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            buck_one_voltage_code_o <= RST_CODE;
        end else begin
            buck_one_voltage_code_o <= code_r;
        end
    end

    // mode flag, kept as a flop of its own so the output has no gate
    // between register and pin
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            reg_mode_o <= 1'b1;
        end else begin
            reg_mode_o <= !xsel_r;
        end
    end

    // requested output voltage; in external mode the code has no meaning,
    // so zero is reported rather than a stale figure
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            target_mv_o <= RST_MV;
        end else if (xsel_r) begin
            target_mv_o <= {`BVS_MV_W{1'b0}};
        end else begin
            target_mv_o <= mv_w;
        end
    end

    // key wipe request: one pulse after each finished transaction; a key
    // that was not used by that transaction is lost as well
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            key_clear_o <= 1'b0;
        end else begin
            key_clear_o <= txn_end_i;
        end
    end

    // refused-write pulse, so the host can tell a dropped write from a slow one
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            write_refused_o <= 1'b0;
        end else begin
            write_refused_o <= refuse_w;
        end
    end

endmodule

// [tb/bvs_chk.sv]
// port relations of the voltage-select register
`timescale 1ns/100ps
module bvs_chk #(parameter [1:0] VARIANT = 2'h0) (
    input wire clk_i, input wire reset_n_i, input wire txn_end_i, input wire wr_en_i,
    input wire [7:0] wr_addr_i, input wire [7:0] wr_data_i, input wire [7:0] rd_addr_i,
    input wire [7:0] unlock_key_i, input wire [7:0] rd_data_o,
    input wire external_voltage_select_o, input wire [5:0] buck_one_voltage_code_o,
    input wire reg_mode_o, input wire [11:0] target_mv_o, input wire key_clear_o,
    input wire write_refused_o);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    // a write to this register while the key is wrong
    wire lk = wr_en_i && wr_addr_i == 8'h0e && unlock_key_i != 8'h7d;
    rst_code_a: assert property ($rose(reset_n_i) |-> !external_voltage_select_o &&
        buck_one_voltage_code_o == 6'h1e - 6'h06 * VARIANT) else $error("bad reset code");
    src_mode_a: assert property (reg_mode_o == !external_voltage_select_o)
        else $error("mode disagrees with select");
    read_fields_a: assert property (rd_addr_i == 8'h0e && $past(rd_addr_i) == 8'h0e &&
        !wr_en_i && !$past(wr_en_i) |-> rd_data_o[7] == external_voltage_select_o &&
        rd_data_o[5:0] == buck_one_voltage_code_o) else $error("read fields wrong");
    lock_flag_a: assert property (lk |-> ##[0:2] write_refused_o)
        else $error("locked write not flagged");
    lock_hold_a: assert property (lk |=> $stable(buck_one_voltage_code_o) [*2])
        else $error("locked write changed code");
    key_wipe_a: assert property (txn_end_i && unlock_key_i != 8'h00 |->
        ##[0:2] key_clear_o) else $error("key not wiped");
    top_volt_a: assert property (reg_mode_o && $stable(buck_one_voltage_code_o) &&
        buck_one_voltage_code_o >= 6'h38 |-> target_mv_o == 12'hce4) else $error("top step");
endmodule
bind bvs_buck_voltage_select bvs_chk #(.VARIANT(VARIANT)) u_chk (.clk_i(clk_i),
    .reset_n_i(reset_n_i), .txn_end_i(txn_end_i), .wr_en_i(wr_en_i), .wr_addr_i(wr_addr_i),
    .wr_data_i(wr_data_i), .rd_addr_i(rd_addr_i), .unlock_key_i(unlock_key_i),
    .rd_data_o(rd_data_o), .external_voltage_select_o(external_voltage_select_o),
    .buck_one_voltage_code_o(buck_one_voltage_code_o), .reg_mode_o(reg_mode_o),
    .target_mv_o(target_mv_o), .key_clear_o(key_clear_o), .write_refused_o(write_refused_o));

// [tb/bvs_host_key.sv]
// host-side password register model feeding the unlock key
`timescale 1ns/100ps
module bvs_host_key (input wire clk_i, input wire reset_n_i, input wire set_i,
    input wire [7:0] key_i, input wire key_clear_i, output reg [7:0] key_o);
    // the key lives for one transaction only, then the device wipes it
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) key_o <= 8'h00;
        else if (key_clear_i) key_o <= 8'h00;
        else if (set_i) key_o <= key_i;
    end
endmodule

// [tb/tb_bvs_buck_voltage_select.sv]
// testbench of the voltage-select register
`timescale 1ns/100ps
module tb_bvs_buck_voltage_select;
    reg clk_i = 0, reset_n_i = 0, txn_end_i = 0, wr_en_i = 0, set_key = 0;
    reg [7:0] wr_addr_i = 0, wr_data_i = 0, rd_addr_i = 8'h0e, key_val = 0;
    reg [47:0] tbl = {6'h00, 6'h18, 6'h19, 6'h34, 6'h35, 6'h37, 6'h38, 6'h3f};
    wire [7:0] key, rd_data;
    wire sel, mode, clr, refused;
    wire [5:0] code;
    wire [11:0] mv;
    integer mismatches = 0, comparisons = 0, i;
    bvs_host_key u_key (.clk_i(clk_i), .reset_n_i(reset_n_i), .set_i(set_key),
        .key_i(key_val), .key_clear_i(clr), .key_o(key));
    bvs_buck_voltage_select #(.VARIANT(2'h2)) u_dut (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .txn_end_i(txn_end_i), .wr_en_i(wr_en_i), .wr_addr_i(wr_addr_i), .wr_data_i(wr_data_i),
        .rd_addr_i(rd_addr_i), .unlock_key_i(key), .rd_data_o(rd_data),
        .external_voltage_select_o(sel), .buck_one_voltage_code_o(code), .reg_mode_o(mode),
        .target_mv_o(mv), .key_clear_o(clr), .write_refused_o(refused));
    function [11:0] mv_of(input [5:0] c);
        mv_of = c <= 6'h18 ? 12'h384 + c * 12'h019 : c <= 6'h34 ? 12'h5dc + (c - 6'h18) * 12'h032
            : c < 6'h38 ? 12'hbb8 + (c - 6'h35) * 12'h064 : 12'hce4;
    endfunction
    task chk(input [11:0] got, input [11:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                mismatches = mismatches + 1;
                $display("MISMATCH %0t got %h want %h", $time, got, exp);
            end
        end
    endtask
    // a zero key leaves the password register untouched
    task wr(input [7:0] k, input [7:0] a, input [7:0] d);
        begin
            @(negedge clk_i) set_key = |k;
            key_val = k;
            @(negedge clk_i) set_key = 0;
            wr_en_i = 1;
            wr_addr_i = a;
            wr_data_i = d;
            @(negedge clk_i) wr_en_i = 0;
            txn_end_i = 1;
            @(negedge clk_i) txn_end_i = 0;
            repeat (2) @(negedge clk_i);
        end
    endtask
    task stop_test;
        begin
            $display("comparisons %0d mismatches %0d", comparisons, mismatches);
            if (mismatches == 0 && comparisons > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    initial forever #4 clk_i = ~clk_i;
    initial begin
        #20000 mismatches = mismatches + 1;
        stop_test;
    end
    initial begin
        repeat (4) @(negedge clk_i);
        reset_n_i = 1;
        repeat (2) @(negedge clk_i);
        chk(rd_data, 8'h12);
        chk(mv, 12'h546);
        wr(8'h7d, 8'h0f, 8'h3f); // key spent on another register
        chk(rd_data, 8'h12);
        for (i = 0; i < 4; i = i + 1) begin
            wr(8'h7e * (i & 1) + 8'h81 * (i >> 1), 8'h0e, 8'h3f);
            chk(rd_data, 8'h12);
        end
        for (i = 0; i < 8; i = i + 1) begin
            wr(8'h7d, 8'h0e, {2'b00, tbl[i*6 +: 6]});
            chk(rd_data, {2'b00, tbl[i*6 +: 6]});
            chk(mv, mv_of(tbl[i*6 +: 6]));
            chk(mode, 1'b1);
        end
        wr(8'h7d, 8'h0e, 8'h85);
        chk(rd_data, 8'h85);
        chk(mode, 1'b0);
        chk(sel, 1'b1);
        chk(code, 6'h05);
        rd_addr_i = 8'h0f;
        repeat (2) @(negedge clk_i);
        chk(rd_data, 8'h00);
        stop_test;
    end
endmodule
